/* pkg/memmap_defines.svh */
// Address map constants for program and data memory decoding
`ifndef MEMMAP_DEFINES_SVH
`define MEMMAP_DEFINES_SVH

`define PC_W          13
`define PROG_IDX_W    10
`define RESET_VEC     13'h0000
`define IRQ_VEC       13'h0004
`define DADDR_W       9
`define DOFS_W        7
`define DATA_W        8
`define SPECIAL_TOP   7'h1F
`define RAM_LO        7'h40
`define RAM_HI        7'h6F
`define COMMON_LO     7'h70
`define RAM_DEPTH     64
`define RAM_IDX_W     6
`define INDIRECT_OFS  7'h00
`define RAM_IDX_BASE  6'h00
`define COMMON_IDX    6'h30

`endif

/* pkg/memmap_pkg.sv */
// Types shared by the address map design
package memmap_pkg;
  typedef enum logic [1:0] {
    REGION_SPECIAL = 2'b00,
    REGION_RAM     = 2'b01,
    REGION_COMMON  = 2'b10,
    REGION_NONE    = 2'b11
  } region_e;
endpackage : memmap_pkg

/* rtl/data_ram.sv */
// General purpose storage of 64 bytes in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defines.svh"
module data_ram (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  // Access port
  input  wire logic                    wr_en_i,
  input  wire logic [`RAM_IDX_W-1:0]   idx_i,
  input  wire logic [`DATA_W-1:0]      wdata_i,
  output logic      [`DATA_W-1:0]      rdata_o
);
  logic [`DATA_W-1:0] mem_ff [`RAM_DEPTH];

  // ----------------------------------------
  // Storage cells
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RAM_DEPTH; g++) begin : g_cell
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
          mem_ff[g] <= 8'h00;
        end else if (wr_en_i && idx_i == `RAM_IDX_W'(g)) begin
          mem_ff[g] <= wdata_i;
        end
      end
    end
  endgenerate

  assign rdata_o = mem_ff[idx_i];
endmodule : data_ram
`default_nettype wire

/* rtl/memmap_top.sv */
// Program fetch and banked data address decoder
// What this block does
// - Program counter is 13 bits, 8K x14
// - Fetches above 03FFh wrap into 1K
// - Reset starts 0000h, interrupt goes 0004h
// - Data memory split into four banks
// - Lowest 32 addresses per bank are special
// - Bank 0 40h-6Fh is general RAM
// - Top 16 of every bank share 70h-7Fh
// - Unimplemented data locations read zero
// - Bank select bits index the bank binary
// - General RAM holds 64 bytes
// - Indirect pointer reaches every location; direct offset 00h uses the pointer
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defines.svh"
module memmap_top
  import memmap_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  // Program fetch control from core
  input  wire logic                  pc_load_i,
  input  wire logic [`PC_W-1:0]      pc_next_i,
  input  wire logic                  irq_take_i,
  // Program fetch address
  output logic      [`PC_W-1:0]      pc_o,
  output logic      [`PROG_IDX_W-1:0] prog_addr_o,
  // Data access from core
  input  wire logic                  data_req_i,
  input  wire logic                  data_we_i,
  input  wire logic                  indirect_i,
  input  wire logic [`DOFS_W-1:0]    direct_ofs_i,
  input  wire logic [`DATA_W-1:0]    wdata_i,
  input  wire logic [1:0]            bank_select_bits_i,
  input  wire logic                  indirect_bank_hi_i,
  input  wire logic [`DATA_W-1:0]    indirect_pointer_i,
  input  wire logic [`DATA_W-1:0]    special_rdata_i,
  // Data decode results
  output logic      [`DADDR_W-1:0]   data_addr_o,
  output logic      [1:0]            bank_o,
  output logic      [1:0]            region_o,
  output logic                       special_sel_o,
  output logic                       special_we_o,
  output logic      [`DATA_W-1:0]    rdata_o,
  output logic                       rdata_valid_o
);

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  logic [`PC_W-1:0] pc_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pc_ff <= `RESET_VEC;
    end else if (irq_take_i) begin
      pc_ff <= `IRQ_VEC;
    end else if (pc_load_i) begin
      pc_ff <= pc_next_i;
    end else begin
      pc_ff <= pc_ff + 13'h0001;
    end
  end

  assign pc_o = pc_ff;

  logic [`PROG_IDX_W-1:0] prog_addr_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prog_addr_ff <= 10'h000;
    end else if (irq_take_i) begin
      prog_addr_ff <= `PROG_IDX_W'(`IRQ_VEC);
    end else if (pc_load_i) begin
      prog_addr_ff <= pc_next_i[`PROG_IDX_W-1:0];
    end else begin
      prog_addr_ff <= prog_addr_ff + 10'h001;
    end
  end

  assign prog_addr_o = prog_addr_ff;

  // ----------------------------------------
  // Data address formation
  // ----------------------------------------
  logic [`DADDR_W-1:0] nxt_addr;
  logic [`DOFS_W-1:0]  ofs;
  logic [1:0]          bank;
  region_e             region;
  logic                use_ptr;

  always_comb begin
    use_ptr = indirect_i || (direct_ofs_i == `INDIRECT_OFS);
    if (use_ptr) begin
      nxt_addr = {indirect_bank_hi_i, indirect_pointer_i};
    end else begin
      nxt_addr = {bank_select_bits_i, direct_ofs_i};
    end
    bank = nxt_addr[`DADDR_W-1:`DOFS_W];
    ofs  = nxt_addr[`DOFS_W-1:0];
    if (ofs <= `SPECIAL_TOP) begin
      region = REGION_SPECIAL;
    end else if (ofs >= `COMMON_LO) begin
      region = REGION_COMMON;
    end else if (bank == 2'b00 && ofs >= `RAM_LO && ofs <= `RAM_HI) begin
      region = REGION_RAM;
    end else begin
      region = REGION_NONE;
    end
  end

  // ----------------------------------------
  // General RAM
  // ----------------------------------------
  logic [`RAM_IDX_W-1:0] ram_idx;
  logic [`DATA_W-1:0]    ram_rdata;
  logic                  ram_we;

  always_comb begin
    case (region)
      REGION_RAM:    ram_idx = `RAM_IDX_W'(ofs - `RAM_LO);
      REGION_COMMON: ram_idx = `COMMON_IDX + {2'b00, ofs[3:0]};
      default:       ram_idx = `RAM_IDX_BASE;
    endcase
  end

  assign ram_we = data_req_i && data_we_i &&
                  (region == REGION_RAM || region == REGION_COMMON);

  data_ram u_ram (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (ram_we),
    .idx_i     (ram_idx),
    .wdata_i   (wdata_i),
    .rdata_o   (ram_rdata)
  );

  // ----------------------------------------
  // Registered decode outputs
  // ----------------------------------------
  logic [`DADDR_W-1:0] addr_ff;
  logic [1:0]          bank_ff;
  logic [1:0]          region_ff;
  logic                special_sel_ff;
  logic                special_we_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_ff        <= 9'h000;
      bank_ff        <= 2'h0;
      region_ff      <= 2'h3;
      special_sel_ff <= 1'b0;
      special_we_ff  <= 1'b0;
    end else begin
      addr_ff        <= nxt_addr;
      bank_ff        <= bank;
      region_ff      <= region;
      special_sel_ff <= data_req_i && (region == REGION_SPECIAL);
      special_we_ff  <= data_req_i && data_we_i && (region == REGION_SPECIAL);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [`DATA_W-1:0] rdata_ff;
  logic               rvalid_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= data_req_i && !data_we_i;
      if (data_req_i && !data_we_i) begin
        case (region)
          REGION_SPECIAL: rdata_ff <= special_rdata_i;
          REGION_RAM:     rdata_ff <= ram_rdata;
          REGION_COMMON:  rdata_ff <= ram_rdata;
          default:        rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  assign data_addr_o   = addr_ff;
  assign bank_o        = bank_ff;
  assign region_o      = region_ff;
  assign special_sel_o = special_sel_ff;
  assign special_we_o  = special_we_ff;
  assign rdata_o       = rdata_ff;
  assign rdata_valid_o = rvalid_ff;
endmodule : memmap_top
`default_nettype wire

/* tb/core_model.sv */
// Processor side model returning special location data
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic [6:0] ofs_i,
  output logic      [7:0] special_rdata_o
);
  assign special_rdata_o = {1'b1, ofs_i};
endmodule : core_model
`default_nettype wire

/* tb/memmap_properties.sv */
// Concurrent checks on the address map decoder ports
`timescale 1ns/1ps
`default_nettype none
module memmap_properties (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        pc_load_i,
  input wire logic [12:0] pc_next_i,
  input wire logic        irq_take_i,
  input wire logic [12:0] pc_o,
  input wire logic [9:0]  prog_addr_o,
  input wire logic        data_req_i,
  input wire logic        data_we_i,
  input wire logic        indirect_i,
  input wire logic [6:0]  direct_ofs_i,
  input wire logic [1:0]  bank_select_bits_i,
  input wire logic [8:0]  data_addr_o,
  input wire logic [1:0]  region_o,
  input wire logic        special_sel_o,
  input wire logic        special_we_o,
  input wire logic [7:0]  rdata_o,
  input wire logic        rdata_valid_o
);
  logic dir;
  assign dir = data_req_i && !indirect_i && (direct_ofs_i != 7'h00);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_PC_WRAP: assert property (prog_addr_o == pc_o[9:0])
    else $error("fetch index differs");
  AST_PC_RESET: assert property ($rose(rst_n_i) |-> pc_o == 13'h0000)
    else $error("pc not zero after reset");
  AST_PC_IRQ: assert property (irq_take_i |=> pc_o == 13'h0004)
    else $error("interrupt vector wrong");
  AST_PC_STEP: assert property (!irq_take_i && !pc_load_i |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("pc step wrong");
  AST_PC_LOAD: assert property (pc_load_i && !irq_take_i |=> pc_o == $past(pc_next_i))
    else $error("pc load wrong");
  AST_SPECIAL: assert property (dir && direct_ofs_i <= 7'h1F |=> special_sel_o && region_o == 2'h0)
    else $error("special decode wrong");
  AST_SPECIAL_WE: assert property (
    dir && data_we_i && direct_ofs_i <= 7'h1F |=> special_we_o)
    else $error("special write strobe wrong");
  AST_RAM: assert property (
    dir && bank_select_bits_i == 2'h0 && direct_ofs_i inside {[7'h40:7'h6F]}
    |=> region_o == 2'h1)
    else $error("ram decode wrong");
  AST_COMMON: assert property (dir && direct_ofs_i >= 7'h70 |=> region_o == 2'h2)
    else $error("common decode wrong");
  AST_NONE_READ: assert property (
    dir && !data_we_i && direct_ofs_i inside {[7'h20:7'h3F]}
    |=> rdata_valid_o && rdata_o == 8'h00)
    else $error("unimplemented read not zero");
  AST_DIRECT_ADDR: assert property (
    dir |=> data_addr_o == {$past(bank_select_bits_i), $past(direct_ofs_i)})
    else $error("direct address wrong");
endmodule : memmap_properties
bind memmap_top memmap_properties i_memmap_properties (.*);
`default_nettype wire

/* tb/memmap_top_test.sv */
// Self-checking bench for the address map decoder
`timescale 1ns/1ps
`default_nettype none
module memmap_top_test;
  logic        clk = 0, rst_n = 0, ld = 0, irq = 0, req = 0, we = 0, ind = 0, ssel, swe, rv;
  logic        ihi = 1'b0;
  logic [12:0] nxt = 0, pc;
  logic [9:0]  pa;
  logic [6:0]  ofs = 0;
  logic [7:0]  wd = 0, ptr = 0, srd, rd;
  logic [8:0]  daddr;
  logic [1:0]  bank = 0, bq, reg_q;
  int          failures = 0, checked = 0;
  core_model i_core_model (.ofs_i(ofs), .special_rdata_o(srd));
  memmap_top i_memmap_top (.ref_clk_i(clk), .rst_n_i(rst_n), .pc_load_i(ld), .pc_next_i(nxt),
    .irq_take_i(irq), .pc_o(pc), .prog_addr_o(pa), .data_req_i(req), .data_we_i(we),
    .indirect_i(ind), .direct_ofs_i(ofs), .wdata_i(wd), .bank_select_bits_i(bank),
    .indirect_bank_hi_i(ihi), .indirect_pointer_i(ptr), .special_rdata_i(srd),
    .data_addr_o(daddr), .bank_o(bq), .region_o(reg_q), .special_sel_o(ssel),
    .special_we_o(swe), .rdata_o(rd), .rdata_valid_o(rv));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask : cyc
  task automatic acc(input logic w, i, input logic [1:0] b, input logic [6:0] o,
                     input logic [7:0] d, p, e);
    req = 1; we = w; ind = i; bank = b; ofs = o; wd = d; ptr = p;
    cyc;
    req = 0;
    if (!w) begin
      chk(rv, 1'b1);
      chk(rd, e);
    end
    if (!i) chk(daddr, {b, o});
    cyc;
  endtask : acc
  task automatic fetch_scn;
    chk(pc, 13'h0000);
    cyc;
    chk(pc, 13'h0001);
    irq = 1; ld = 1; nxt = 13'h0123;
    cyc;
    irq = 0; nxt = 13'h1FFF;
    chk(pc, 13'h0004);
    cyc;
    ld = 0;
    chk(pc, 13'h1FFF);
    chk(pa, 10'h3FF);
    cyc;
    chk(pc, 13'h0000);
  endtask : fetch_scn
  task automatic data_scn;
    acc(1, 0, 2'h3, 7'h70, 8'hA5, 8'h00, 8'h00);
    acc(0, 0, 2'h0, 7'h70, 8'h00, 8'h00, 8'hA5);
    acc(1, 0, 2'h0, 7'h40, 8'h3C, 8'h00, 8'h00);
    acc(1, 0, 2'h0, 7'h6F, 8'hC3, 8'h00, 8'h00);
    acc(0, 1, 2'h2, 7'h00, 8'h00, 8'h40, 8'h3C);
    acc(0, 0, 2'h0, 7'h6F, 8'h00, 8'h00, 8'hC3);
    acc(1, 0, 2'h1, 7'h40, 8'h77, 8'h00, 8'h00);
    acc(0, 0, 2'h1, 7'h40, 8'h00, 8'h00, 8'h00);
    acc(0, 0, 2'h0, 7'h2A, 8'h00, 8'h00, 8'h00);
    ihi = 1'b1;
    acc(0, 1, 2'h0, 7'h00, 8'h00, 8'hF0, 8'hA5);
    chk(daddr, 9'h1F0);
    ihi = 1'b0;
    for (int b = 0; b < 4; b++) begin
      acc(0, 0, b[1:0], 7'h05, 8'h00, 8'h00, 8'h85);
      chk(bq, b[1:0]);
    end
  endtask : data_scn
  task automatic special_scn;
    req = 1; we = 1; ind = 0; bank = 2'h2; ofs = 7'h0C;
    cyc;
    req = 0;
    chk(ssel, 1'b1);
    chk(swe, 1'b1);
    chk(reg_q, 2'h0);
    chk(rv, 1'b0);
    cyc;
    chk(ssel, 1'b0);
    chk(swe, 1'b0);
  endtask : special_scn
  task automatic print_verdict;
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    fetch_scn;
    data_scn;
    special_scn;
    print_verdict;
  end
endmodule : memmap_top_test
`default_nettype wire
